//--- src/pcg_map.svh
// register map, field positions, reset values and timing counts
// assumes an 8-bit register port clocked by mclk at 200 MHz
//
// Summary of operation
// - no start-up timer on exit from idle
// - skip start-up timer unless crystal oscillator mode
// - always wait CPU-prepare delay, then resume
// - idle stops CPU clock, peripherals keep clocks
// - set disable bit gates that peripheral's clock
// - disabled peripheral ignores writes, reads invalid
// - clearing disable bit reinitialises peripheral registers
// - one disconnects clock and power; zero connects
// - first register: serial ports, timers; resets zero
// - second register: sync serial, capture units; zero
// - second register bit five reads zero
// - third register: four low bits, rest zero
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCG_OFF_DIS0 3'h0
`define PCG_OFF_DIS1 3'h1
`define PCG_OFF_DIS2 3'h2
`define PCG_OFF_WCFG 3'h3
`define PCG_OFF_STAT 3'h4
`define PCG_OFF_RUN0 3'h5
`define PCG_OFF_RUN1 3'h6
`define PCG_OFF_RUN2 3'h7

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PCG_DIS0_MASK 8'hff
`define PCG_DIS1_MASK 8'hdf
`define PCG_DIS2_MASK 8'h0f
`define PCG_DIS_RST 8'h00
`define PCG_WCFG_RST 3'h4
`define PCG_STAT_CPU_BIT 3
`define PCG_STAT_RUN_BIT 4
`define PCG_NPER 19

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCG_MCLK_NS 5
`define PCG_TCSD_NS 100

`endif

//--- src/pcg_pkg.sv
// types shared by the peripheral clock gating block
// assumes pcg_map.svh supplies the numeric constants
package pcg_pkg;

  typedef enum logic [2:0] {
    low_power_crystal_mode,
    standard_crystal_mode,
    high_speed_crystal_mode,
    high_speed_crystal_with_multiplier,
    rc_osc_mode,
    ext_clock_mode,
    internal_osc_mode
  } pcg_osc_t;

  typedef enum logic [2:0] {
    st_run,
    st_idle,
    st_sleep,
    st_ost,
    st_prep
  } pcg_wake_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_t;

  typedef struct packed {
    logic [7:0] dis0;
    logic [7:0] dis1;
    logic [7:0] dis2;
    pcg_osc_t osc;
    pcg_wake_t st;
    logic cpu_clk_en;
    logic periph_run;
    logic ost_start;
    logic [7:0] rdata;
  } pcg_top_st_t;

  typedef struct packed {
    logic dis_q;
    logic clk_en;
    logic pwr_on;
    logic reinit;
    logic wr_ok;
    logic rd_ok;
  } pcg_gate_st_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic done;
  } pcg_dly_st_t;

endpackage : pcg_pkg

//--- src/pcg_gate.sv
// one peripheral's clock enable, power and access gate
// assumes tick and dis come from flops on mclk
`timescale 1ns/1ps
module pcg_gate
  import pcg_pkg::*;
(
  input logic mclk,
  input logic reset,
  input logic tick,
  input logic dis,
  input logic acc_wr,
  input logic acc_rd,
  output logic clk_en,
  output logic pwr_on,
  output logic reinit,
  output logic wr_ok,
  output logic rd_ok
);

  pcg_gate_st_t s_reg;
  pcg_gate_st_t s_next;

  // an enable that only moves on mclk edges cannot slice a pulse
  always_comb begin
    s_next = s_reg;
    s_next.dis_q = dis;
    s_next.pwr_on = !dis;
    s_next.clk_en = tick && !dis;
    s_next.reinit = s_reg.dis_q && !dis;
    s_next.wr_ok = acc_wr && !dis;
    s_next.rd_ok = acc_rd && !dis;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clk_en = s_reg.clk_en;
  assign pwr_on = s_reg.pwr_on;
  assign reinit = s_reg.reinit;
  assign wr_ok = s_reg.wr_ok;
  assign rd_ok = s_reg.rd_ok;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_set_clear;
    dis ##1 !dis;
  endsequence

  property p_gate_off;
    @(posedge mclk) disable iff (reset) dis |=> !clk_en && !pwr_on;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("clock still on while disabled");

  property p_gate_on;
    @(posedge mclk) disable iff (reset)
      (!dis && tick) |=> clk_en && pwr_on;
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("enabled peripheral not clocked");

  property p_no_access;
    @(posedge mclk) disable iff (reset)
      (dis && (acc_wr || acc_rd)) |=> !wr_ok && !rd_ok;
  endproperty
  a_no_access: assert property (p_no_access)
    else $error("access passed to disabled peripheral");

  property p_reinit;
    @(posedge mclk) disable iff (reset)
      s_set_clear |=> reinit ##1 !reinit;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("no single reinit pulse on re-enable");

  property p_clean_edge;
    @(posedge mclk) disable iff (reset)
      $fell(clk_en) |-> $past(dis) || !$past(tick);
  endproperty
  a_clean_edge: assert property (p_clean_edge)
    else $error("clock enable dropped without cause");

endmodule : pcg_gate

//--- src/pcg_delay.sv
// fixed countdown: done pulses CYC+1 cycles after start
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/1ps
module pcg_delay
  import pcg_pkg::*;
#(
  parameter int CYC = 20
) (
  input logic mclk,
  input logic reset,
  input logic start,
  output logic busy,
  output logic done
);

  pcg_dly_st_t s_reg;
  pcg_dly_st_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.busy = 1'b1;
      s_next.cnt = 16'(CYC - 1);
    end else if (s_reg.busy && s_reg.cnt == 16'h0000) begin
      s_next.busy = 1'b0;
      s_next.done = 1'b1;
    end else if (s_reg.busy) begin
      s_next.cnt = s_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.busy;
  assign done = s_reg.done;

endmodule : pcg_delay

//--- src/pcg_top.sv
// peripheral clock gating and wake sequencing, register port on mclk
// assumes sleep, wake and start-up timer signals come from mclk logic
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_top
  import pcg_pkg::*;
#(
  parameter int TCSD_CYC =
    (`PCG_TCSD_NS + `PCG_MCLK_NS - 1) / `PCG_MCLK_NS
) (
  input logic mclk,
  input logic reset,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  input logic sleep_cmd,
  input logic idle_en,
  input logic wake_evt,
  input logic ost_done,
  output logic cpu_clk_en,
  output logic ost_start,
  input logic [4:0] per_idx,
  input logic per_wr,
  input logic per_rd,
  output logic [`PCG_NPER-1:0] periph_clk_en,
  output logic [`PCG_NPER-1:0] periph_pwr_on,
  output logic [`PCG_NPER-1:0] periph_reinit,
  output logic [`PCG_NPER-1:0] per_wr_ok,
  output logic [`PCG_NPER-1:0] per_rd_ok
);

  localparam int NP = `PCG_NPER;
  localparam int RESUME_CYC = TCSD_CYC + 1;

  pcg_top_st_t s_reg;
  pcg_top_st_t s_next;
  pcg_bus_t bus;
  logic [NP-1:0] dis_vec;
  logic [NP-1:0] acc_wr;
  logic [NP-1:0] acc_rd;
  logic need_ost;
  logic xtal;
  logic dly_start;
  logic dly_busy;
  logic dly_done;

  assign bus.addr = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr = reg_wr;
  assign bus.rd = reg_rd;

  // ----------------------------------------------------------------
  // peripheral index order
  // ----------------------------------------------------------------
  // 0..7 first register, 8..12 capture units, 13..14 sync serial,
  // 15..18 third register low bits
  assign dis_vec = {
    s_reg.dis2[3:0],
    s_reg.dis1[7:6],
    s_reg.dis1[4:0],
    s_reg.dis0
  };

  // ----------------------------------------------------------------
  // wake decision
  // ----------------------------------------------------------------
  // only the four crystal modes need the oscillator to settle
  always_comb begin
    unique case (s_reg.osc)
      low_power_crystal_mode: xtal = 1'b1;
      standard_crystal_mode: xtal = 1'b1;
      high_speed_crystal_mode: xtal = 1'b1;
      high_speed_crystal_with_multiplier: xtal = 1'b1;
      default: xtal = 1'b0;
    endcase
  end

  // idle never stops the running source, so only sleep can need it
  assign need_ost = (s_reg.st == st_sleep) && xtal;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ost_start = 1'b0;
    s_next.rdata = 8'h00;
    dly_start = 1'b0;

    // register writes; unused bits are never stored
    if (bus.wr) begin
      unique case (bus.addr)
        `PCG_OFF_DIS0: begin
          s_next.dis0 = bus.wdata & `PCG_DIS0_MASK;
        end
        `PCG_OFF_DIS1: begin
          s_next.dis1 = bus.wdata & `PCG_DIS1_MASK;
        end
        `PCG_OFF_DIS2: begin
          s_next.dis2 = bus.wdata & `PCG_DIS2_MASK;
        end
        `PCG_OFF_WCFG: begin
          s_next.osc = pcg_osc_t'(bus.wdata[2:0]);
        end
        default: begin
        end
      endcase
    end

    // register reads, answered one cycle later
    if (bus.rd) begin
      unique case (bus.addr)
        `PCG_OFF_DIS0: begin
          s_next.rdata = s_reg.dis0;
        end
        `PCG_OFF_DIS1: begin
          s_next.rdata = s_reg.dis1 & `PCG_DIS1_MASK;
        end
        `PCG_OFF_DIS2: begin
          s_next.rdata = s_reg.dis2 & `PCG_DIS2_MASK;
        end
        `PCG_OFF_WCFG: begin
          s_next.rdata = {5'h00, s_reg.osc};
        end
        `PCG_OFF_STAT: begin
          s_next.rdata = {3'h0, s_reg.periph_run, s_reg.cpu_clk_en,
                          s_reg.st};
        end
        `PCG_OFF_RUN0: begin
          s_next.rdata = periph_clk_en[7:0];
        end
        `PCG_OFF_RUN1: begin
          s_next.rdata = {periph_clk_en[14:13], 1'b0,
                          periph_clk_en[12:8]};
        end
        `PCG_OFF_RUN2: begin
          s_next.rdata = {4'h0, periph_clk_en[18:15]};
        end
        default: begin
        end
      endcase
    end

    // power-managed mode sequencing
    unique case (s_reg.st)
      st_run: begin
        if (sleep_cmd) begin
          s_next.st = idle_en ? st_idle : st_sleep;
        end
      end
      st_idle, st_sleep: begin
        if (wake_evt && need_ost) begin
          s_next.st = st_ost;
          s_next.ost_start = 1'b1;
        end else if (wake_evt) begin
          s_next.st = st_prep;
          dly_start = 1'b1;
        end
      end
      st_ost: begin
        if (ost_done) begin
          s_next.st = st_prep;
          dly_start = 1'b1;
        end
      end
      st_prep: begin
        if (dly_done) begin
          s_next.st = st_run;
        end
      end
      default: begin
        s_next.st = st_run;
      end
    endcase

    // cpu runs only in run; peripherals stop only while sleeping or waiting on the start-up timer
    s_next.cpu_clk_en = (s_next.st == st_run);
    s_next.periph_run = !(s_next.st == st_sleep ||
                          s_next.st == st_ost);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg.dis0 <= `PCG_DIS_RST;
      s_reg.dis1 <= `PCG_DIS_RST;
      s_reg.dis2 <= `PCG_DIS_RST;
      s_reg.osc <= pcg_osc_t'(`PCG_WCFG_RST);
      s_reg.st <= st_run;
      s_reg.cpu_clk_en <= 1'b1;
      s_reg.periph_run <= 1'b1;
      s_reg.ost_start <= 1'b0;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign cpu_clk_en = s_reg.cpu_clk_en;
  assign ost_start = s_reg.ost_start;

  // ----------------------------------------------------------------
  // cpu preparation delay
  // ----------------------------------------------------------------
  pcg_delay #(
    .CYC(TCSD_CYC)
  ) u_prep (
    .mclk(mclk),
    .reset(reset),
    .start(dly_start),
    .busy(dly_busy),
    .done(dly_done)
  );

  // ----------------------------------------------------------------
  // per-peripheral gates
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_per
      assign acc_wr[gi] = per_wr && (per_idx == 5'(gi));
      assign acc_rd[gi] = per_rd && (per_idx == 5'(gi));
      pcg_gate u_gate (
        .mclk(mclk),
        .reset(reset),
        .tick(s_reg.periph_run),
        .dis(dis_vec[gi]),
        .acc_wr(acc_wr[gi]),
        .acc_rd(acc_rd[gi]),
        .clk_en(periph_clk_en[gi]),
        .pwr_on(periph_pwr_on[gi]),
        .reinit(periph_reinit[gi]),
        .wr_ok(per_wr_ok[gi]),
        .rd_ok(per_rd_ok[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wr_dis0;
    bus.wr && bus.addr == `PCG_OFF_DIS0;
  endsequence

  sequence s_rd_dis0;
    bus.rd && bus.addr == `PCG_OFF_DIS0;
  endsequence

  property p_dis0_back;
    @(posedge mclk) disable iff (reset)
      s_wr_dis0 ##1 s_rd_dis0 |=> reg_rdata == $past(bus.wdata, 2);
  endproperty
  a_dis0_back: assert property (p_dis0_back)
    else $error("first disable register readback wrong");

  property p_dis1_store;
    @(posedge mclk) disable iff (reset)
      (bus.wr && bus.addr == `PCG_OFF_DIS1) |=>
        s_reg.dis1 == ($past(bus.wdata) & 8'hdf);
  endproperty
  a_dis1_store: assert property (p_dis1_store)
    else $error("second disable register not stored");

  property p_dis1_gap;
    @(posedge mclk) disable iff (reset)
      (bus.rd && bus.addr == `PCG_OFF_DIS1) |=> !reg_rdata[5];
  endproperty
  a_dis1_gap: assert property (p_dis1_gap)
    else $error("unimplemented bit five read as one");

  property p_dis2_top;
    @(posedge mclk) disable iff (reset)
      (bus.rd && bus.addr == `PCG_OFF_DIS2) |=>
        reg_rdata[7:4] == 4'h0;
  endproperty
  a_dis2_top: assert property (p_dis2_top)
    else $error("third disable register upper bits set");

  property p_idle_no_ost;
    @(posedge mclk) disable iff (reset)
      (s_reg.st == st_idle && wake_evt) |=>
        !ost_start && s_reg.st == st_prep;
  endproperty
  a_idle_no_ost: assert property (p_idle_no_ost)
    else $error("start-up timer used on idle exit");

  property p_sleep_ost;
    @(posedge mclk) disable iff (reset)
      (s_reg.st == st_sleep && wake_evt) |=> ost_start == $past(xtal);
  endproperty
  a_sleep_ost: assert property (p_sleep_ost)
    else $error("start-up timer choice wrong on sleep exit");

  property p_resume;
    @(posedge mclk) disable iff (reset)
      dly_start |-> ##RESUME_CYC !cpu_clk_en ##1 cpu_clk_en;
  endproperty
  a_resume: assert property (p_resume)
    else $error("cpu not resumed right after preparation delay");

  property p_idle_clocks;
    @(posedge mclk) disable iff (reset)
      (s_reg.st == st_run && sleep_cmd && idle_en) |=>
        !cpu_clk_en && s_reg.periph_run;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("idle clocks wrong");

  property p_dis0_store;
    @(posedge mclk) disable iff (reset)
      (bus.wr && bus.addr == `PCG_OFF_DIS0) |=>
        s_reg.dis0 == $past(bus.wdata);
  endproperty
  a_dis0_store: assert property (p_dis0_store)
    else $error("first disable register not stored");

  property p_dis2_store;
    @(posedge mclk) disable iff (reset)
      (bus.wr && bus.addr == `PCG_OFF_DIS2) |=>
        s_reg.dis2 == ($past(bus.wdata) & 8'h0f);
  endproperty
  a_dis2_store: assert property (p_dis2_store)
    else $error("third disable register not stored");

  // idle keeps every enabled peripheral clocked while the cpu waits
  property p_idle_keeps;
    @(posedge mclk) disable iff (reset)
      s_reg.st == st_idle |->
        !cpu_clk_en ##1 periph_clk_en == $past(~dis_vec);
  endproperty
  a_idle_keeps: assert property (p_idle_keeps)
    else $error("idle stopped an enabled peripheral clock");

  property p_prep_busy;
    @(posedge mclk) disable iff (reset)
      s_reg.st == st_prep |-> (dly_busy || dly_done) && !cpu_clk_en;
  endproperty
  a_prep_busy: assert property (p_prep_busy)
    else $error("cpu preparation wait not running");

  property p_access_gate;
    @(posedge mclk) disable iff (reset)
      (per_wr || per_rd) |=>
        ((per_wr_ok | per_rd_ok) & $past(dis_vec)) == '0;
  endproperty
  a_access_gate: assert property (p_access_gate)
    else $error("disabled peripheral passed an access");

endmodule : pcg_top

//--- tb/pcg_partner.sv
// far-side model: oscillator start-up timer answering ost_start
// assumes ost_start is a one-cycle registered pulse on mclk
`timescale 1ns/1ps
module pcg_partner #(
  parameter int OST_CYC = 6
) (
  input logic mclk,
  input logic reset,
  input logic ost_start,
  output logic ost_done
);
  // ----------------------------------------------------------------
  // start-up countdown
  // ----------------------------------------------------------------
  int cnt;
  logic run;

  // never answers at once: the crystal always needs time to settle
  always @(posedge mclk) begin
    ost_done <= !reset && !ost_start && run && cnt == 1;
    if (reset) begin
      run <= 1'b0;
    end else if (ost_start) begin
      run <= 1'b1;
      cnt <= OST_CYC;
    end else if (run) begin
      run <= (cnt != 1);
      cnt <= cnt - 1;
    end
  end
endmodule : pcg_partner

//--- tb/tb_peripheral_clock_gating.sv
// self-checking bench for the peripheral clock gating block
// assumes the start-up timer model in pcg_partner.sv
`timescale 1ns/1ps
`include "pcg_map.svh"
module tb_peripheral_clock_gating import pcg_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TCSD = 2;
  localparam logic [18:0] ALL = 19'h7ffff;
  logic mclk = 1'b0, reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic sleep_cmd = 1'b0, idle_en = 1'b0, wake_evt = 1'b0, ost_done;
  logic cpu_clk_en, ost_start;
  logic [4:0] per_idx = 5'h00;
  logic per_wr = 1'b0, per_rd = 1'b0;
  logic [18:0] clk_en, pwr_on, reinit, wr_ok, rd_ok;
  int n_errors = 0, check_count = 0;
  logic [7:0] d;

  always #2.5 mclk = ~mclk;

  pcg_top #(.TCSD_CYC(TCSD)) dut (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_cmd(sleep_cmd),
    .idle_en(idle_en), .wake_evt(wake_evt), .ost_done(ost_done),
    .cpu_clk_en(cpu_clk_en), .ost_start(ost_start), .per_idx(per_idx),
    .per_wr(per_wr), .per_rd(per_rd), .periph_clk_en(clk_en),
    .periph_pwr_on(pwr_on), .periph_reinit(reinit),
    .per_wr_ok(wr_ok), .per_rd_ok(rd_ok));

  pcg_partner #(.OST_CYC(6)) far (.mclk(mclk), .reset(reset),
    .ost_start(ost_start), .ost_done(ost_done));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task close_out;
    $display("counts: errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task do_reset;
    @(posedge mclk) reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset

  task reg_write(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk) begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
    end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task reg_read(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read

  task per_acc(input logic [4:0] idx, input logic wr);
    @(posedge mclk) begin
      per_idx <= idx;
      per_wr <= wr;
      per_rd <= ~wr;
    end
    @(posedge mclk) begin
      per_wr <= 1'b0;
      per_rd <= 1'b0;
    end
    #1;
  endtask : per_acc

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    logic [7:0] exp [8];
    exp = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h18, 8'hff, 8'hdf, 8'h0f};
    for (int i = 0; i < 8; i++) begin
      reg_read(i[2:0], d);
      chk(d, exp[i]);
    end
    chk(clk_en, ALL);
    chk(pwr_on, ALL);
    chk(cpu_clk_en, 1'b1);
  endtask : t_reset_values

  task t_masks;
    reg_write(`PCG_OFF_DIS0, 8'hff);
    reg_write(`PCG_OFF_DIS1, 8'hff);
    reg_write(`PCG_OFF_DIS2, 8'hff);
    reg_write(`PCG_OFF_RUN0, 8'hff);
    reg_read(`PCG_OFF_DIS0, d);
    chk(d, 8'hff);
    reg_read(`PCG_OFF_DIS1, d);
    chk(d, 8'hdf);
    reg_read(`PCG_OFF_DIS2, d);
    chk(d, 8'h0f);
    reg_read(`PCG_OFF_RUN0, d);
    chk(d, 8'h00);
    chk(clk_en, 19'h0);
    chk(pwr_on, 19'h0);
    for (int i = 0; i < 3; i++) reg_write(i[2:0], 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(clk_en, ALL);
  endtask : t_masks

  task t_access;
    per_acc(5'd15, 1'b1);
    chk(wr_ok, 19'h1 << 15);
    reg_write(`PCG_OFF_DIS2, 8'h01);
    repeat (2) @(posedge mclk);
    per_acc(5'd15, 1'b1);
    chk(wr_ok, 19'h0);
    per_acc(5'd15, 1'b0);
    chk(rd_ok, 19'h0);
    per_acc(5'd14, 1'b0);
    chk(rd_ok, 19'h1 << 14);
    reg_write(`PCG_OFF_DIS2, 8'h00);
    @(posedge mclk);
    #1 chk(reinit, 19'h1 << 15);
    chk(clk_en, ALL);
    @(posedge mclk);
    #1 chk(reinit, 19'h0);
    reg_write(`PCG_OFF_DIS1, 8'h40);
    repeat (2) @(posedge mclk);
    #1 chk(clk_en, ALL & ~(19'h1 << 13));
    reg_write(`PCG_OFF_DIS1, 8'h00);
  endtask : t_access

  // write then read with no gap, as the port allows
  task t_back_to_back;
    @(posedge mclk) begin
      reg_addr <= `PCG_OFF_DIS0;
      reg_wdata <= 8'ha5;
      reg_wr <= 1'b1;
    end
    @(posedge mclk) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
    end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'ha5);
    reg_write(`PCG_OFF_DIS0, 8'h00);
  endtask : t_back_to_back

  // sleep or idle entry, wake, optional start-up timer, resume count
  task t_wake(input logic [2:0] mode, input logic idle);
    int k, n;
    logic oscillator_startup_timer;
    oscillator_startup_timer = !idle && mode < 3'h4;
    reg_write(`PCG_OFF_WCFG, {5'h00, mode});
    @(posedge mclk) begin
      idle_en <= idle;
      sleep_cmd <= 1'b1;
    end
    @(posedge mclk) sleep_cmd <= 1'b0;
    #1 chk(cpu_clk_en, 1'b0);
    repeat (2) @(posedge mclk);
    #1 chk(clk_en, idle ? ALL : 19'h0);
    reg_read(`PCG_OFF_STAT, d);
    chk(d[4:0], {idle, 1'b0, idle ? 3'h1 : 3'h2});
    @(posedge mclk) wake_evt <= 1'b1;
    @(posedge mclk) wake_evt <= 1'b0;
    #1 chk(ost_start, oscillator_startup_timer);
    if (oscillator_startup_timer) begin
      for (k = 0; k < 50; k++) begin
        @(posedge mclk);
        if (ost_done === 1'b1) break;
      end
      if (k == 50) begin
        chk(1'b0, 1'b1);
        close_out();
      end
      #1;
    end
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n, TCSD + 1);
    if (n == 40) begin
      close_out();
    end
    chk(clk_en, ALL);
  endtask : t_wake

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    t_masks();
    t_access();
    t_back_to_back();
    for (int m = 0; m < 8; m++) t_wake(m[2:0], 1'b0);
    t_wake(3'h0, 1'b1);
    t_wake(3'h4, 1'b1);
    reg_write(`PCG_OFF_DIS0, 8'hff);
    do_reset();
    reg_read(`PCG_OFF_DIS0, d);
    chk(d, 8'h00);
    close_out();
  end
endmodule : tb_peripheral_clock_gating
